// ---- rtl/irrx_pkg.sv ----
// types shared by the infrared code receiver register block
// assumes irrx_regs.svh is compiled alongside
package irrx_pkg;

	// ==============================================================
	// coding formats, encoding fixed by the control field
	typedef enum logic [1:0] {
		IRRX_MODE_9012 = 2'h0,
		IRRX_MODE_NEC  = 2'h1,
		IRRX_MODE_RC5  = 2'h2,
		IRRX_MODE_RC6  = 2'h3
	} irrx_mode_t;

	// ==============================================================
	// results handed over by the line decoder, one-cycle pulses
	typedef struct packed {
		logic        frame_done;  // key value frame complete
		logic        repeat_seen; // repeat code complete
		logic        proto_err;   // frame broke the protocol
		logic [15:0] cust_code;   // customer code as received
		logic [7:0]  key_data;
		logic [7:0]  key_anti;    // inverted key, 9012 and nec only
		logic        pad_valid;   // paddle word complete
		logic [19:0] pad_word;
	} irrx_dec_t;

	// ==============================================================
	// settings handed to the line decoder
	typedef struct packed {
		irrx_mode_t  mode;
		logic        rx_enable;
		logic        paddle;
		logic [5:0]  leader_units;
		logic [5:0]  bit_units;
		logic        unit_tick;   // one pulse per 10 us
	} irrx_cfg_t;

endpackage

// ---- rtl/irrx_regblock.sv ----
// register side of the infrared remote code receiver: control, status,
// customer code compare, key capture, paddle buffer and 10 us tick.
// assumes a line decoder on MCLK that reports frames as one-cycle pulses
// and a bus master that never asserts both strobes together.
// Behaviour
// [RQ1] expected customer code width depends on mode
// [RQ2] received customer code readable, same layout
// [RQ3] key layout per mode, anti-key in 15:8
// [RQ4] key updated on key frames, not repeats
// [RQ5] paddle words go into eight-entry buffer
// [RQ6] leader width field 13:8, resets 150 us
// [RQ7] bit width field 5:0, resets 0x15
// [RQ8] software polls or interrupts, never dma
// [RQ9] two-bit field selects the code format
// [RQ10] paddle enable overrides other coding modes
// [RQ11] customer mismatch flag, write-one or auto clear
// [RQ12] interrupt only for fully correct frames; code also sets the receive bit on repeats after a good frame
// [RQ13] reset clears captures, empties buffer, loads defaults
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`include "irrx_regs.svh"
`default_nettype none

module irrx_regblock
(
	input  wire logic                MCLK,
	input  wire logic                SYS_RST,
	input  wire logic [7:0]          BUS_ADDR,
	input  wire logic [31:0]         BUS_WDATA,
	input  wire logic                BUS_WR,
	input  wire logic                BUS_RD,
	output logic [31:0]              BUS_RDATA,
	input  wire irrx_pkg::irrx_dec_t DEC_IN,
	output irrx_pkg::irrx_cfg_t      DEC_CFG,
	output logic                     PAD_OVERFLOW,
	output logic                     IRQ
);
	import irrx_pkg::*;

	// ==============================================================
	// helper functions

	// customer code bits that count for a format
	function automatic logic [15:0] cust_mask(input irrx_mode_t m);
		logic [15:0] r;
		r = 16'h0000;
		unique case (m)
			IRRX_MODE_RC5:  r = 16'h001f;
			IRRX_MODE_RC6:  r = 16'h00ff;
			IRRX_MODE_9012: r = 16'hffff;
			IRRX_MODE_NEC:  r = 16'hffff;
		endcase
		return r;
	endfunction

	// key register bits that a format fills
	function automatic logic [15:0] key_mask(input irrx_mode_t m);
		logic [15:0] r;
		r = 16'h0000;
		unique case (m)
			IRRX_MODE_RC5:  r = 16'h003f;
			IRRX_MODE_RC6:  r = 16'h00ff;
			IRRX_MODE_9012: r = 16'hffff;
			IRRX_MODE_NEC:  r = 16'hffff;
		endcase
		return r;
	endfunction

	// ==============================================================
	// registers
	irrx_mode_t  mode_q;
	logic        paddle_q;
	logic        rxen_q;
	logic        iie_q;
	logic [15:0] exp_cc_q;
	logic [15:0] rcv_cc_q;
	logic [15:0] key_q;
	logic [5:0]  leader_q;
	logic [5:0]  bitw_q;
	logic        cust_mis_q;
	logic        key_mis_q;
	logic        repeat_q;
	logic        rxirq_q;
	logic        proterr_q;
	logic        last_good_q;
	logic [7:0]  ien_q;
	logic        ovf_q;
	logic [31:0] rdata_q;
	logic [11:0] unit_cnt_q;
	logic        unit_tick_q;

	// paddle buffer storage
	logic [19:0] fifo_mem_q [0:`IRRX_FIFO_DEPTH-1];
	logic [2:0]  wr_ptr_q;
	logic [2:0]  rd_ptr_q;
	logic [3:0]  count_q;

	// ==============================================================
	// bus decode
	wire wr_ctl    = BUS_WR && (BUS_ADDR == `IRRX_OFS_CTL);
	wire wr_stat   = BUS_WR && (BUS_ADDR == `IRRX_OFS_STAT);
	wire wr_cc     = BUS_WR && (BUS_ADDR == `IRRX_OFS_CC);
	wire wr_tcount = BUS_WR && (BUS_ADDR == `IRRX_OFS_TCOUNT);
	wire wr_iclr   = BUS_WR && (BUS_ADDR == `IRRX_OFS_ICLR);
	wire wr_ien    = BUS_WR && (BUS_ADDR == `IRRX_OFS_IEN);
	wire rd_kdc    = BUS_RD && (BUS_ADDR == `IRRX_OFS_KDC);

	// status clear comes from either the status word or the clear word
	wire [7:0] clr_bits = (wr_stat || wr_iclr) ? (BUS_WDATA[7:0] & `IRRX_ST_W1C_MASK)
	                                           : 8'h00;

	// ==============================================================
	// decoder event qualification
	// [RQ10] paddle overrides modes
	wire pad_on  = rxen_q && paddle_q;
	wire code_on = rxen_q && !paddle_q;

	// [RQ9] format selects masks
	wire [15:0] cmask = cust_mask(mode_q);
	wire [15:0] kmask = key_mask(mode_q);

	// [RQ1] compare only format bits
	wire cust_ok = ((DEC_IN.cust_code ^ exp_cc_q) & cmask) == 16'h0000;

	// only 9012 and nec carry an anti-key to check against
	wire anti_fmt = (mode_q == IRRX_MODE_9012) || (mode_q == IRRX_MODE_NEC);
	wire key_ok   = !anti_fmt || (DEC_IN.key_anti == ~DEC_IN.key_data);

	wire frame_ev  = code_on && DEC_IN.frame_done;
	wire repeat_ev = code_on && DEC_IN.repeat_seen;
	wire err_ev    = code_on && DEC_IN.proto_err;
	wire good_ev   = frame_ev && cust_ok && key_ok;

	// [RQ12] repeat interrupts only after good frame
	wire irq_set = good_ev || (repeat_ev && last_good_q);

	// ==============================================================
	// paddle buffer handshake
	wire fifo_empty = (count_q == 4'h0);
	wire fifo_full  = (count_q == 4'(`IRRX_FIFO_DEPTH));
	wire push       = pad_on && DEC_IN.pad_valid && !fifo_full;
	wire pop        = rd_kdc && paddle_q && !fifo_empty;
	wire [19:0] fifo_head = fifo_mem_q[rd_ptr_q];

	// ==============================================================
	// status word and interrupt
	// in paddle mode the receive pending bit follows the buffer level
	wire rxirq_view = paddle_q ? !fifo_empty : rxirq_q;
	wire [7:0] stat_word = {!fifo_empty, cust_mis_q, key_mis_q, repeat_q,
	                        1'b0, rxirq_view, 1'b0, proterr_q};

	// the receive bit also needs the control register's own enable
	wire [7:0] irq_gate = {ien_q[7:3], ien_q[2] & iie_q, ien_q[1:0]};
	assign IRQ = |(stat_word & irq_gate);

	// ==============================================================
	// read mux
	wire [31:0] kdc_word = paddle_q ? {12'h000, fifo_head} : {16'h0000, key_q};
	wire [31:0] rd_mux =
		(BUS_ADDR == `IRRX_OFS_CTL)    ? {27'h0, paddle_q, rxen_q, iie_q, mode_q} :
		(BUS_ADDR == `IRRX_OFS_STAT)   ? {24'h0, stat_word} :
		(BUS_ADDR == `IRRX_OFS_CC)     ? {16'h0, exp_cc_q} :
		(BUS_ADDR == `IRRX_OFS_KDC)    ? kdc_word :
		(BUS_ADDR == `IRRX_OFS_TCOUNT) ? {18'h0, leader_q, 2'b00, bitw_q} :
		(BUS_ADDR == `IRRX_OFS_RCC)    ? {16'h0, rcv_cc_q} :
		(BUS_ADDR == `IRRX_OFS_IEN)    ? {24'h0, ien_q} :
		32'h0000_0000;

	// read data valid only in the cycle after the strobe
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
			rdata_q <= 32'h0000_0000;
		else
			rdata_q <= BUS_RD ? rd_mux : 32'h0000_0000;
	end
	assign BUS_RDATA = rdata_q;

	// ==============================================================
	// control, compare value and timing fields
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			mode_q   <= IRRX_MODE_9012;
			paddle_q <= 1'b0;
			rxen_q   <= 1'b0;
			iie_q    <= 1'b0;
			exp_cc_q <= 16'h0000;
			// [RQ13] timing defaults load
			leader_q <= `IRRX_LEADER_RST;
			bitw_q   <= `IRRX_BITW_RST;
			ien_q    <= 8'h00;
		end
		else
		begin
			if (wr_ctl)
			begin
				mode_q   <= irrx_mode_t'(BUS_WDATA[1:0]);
				iie_q    <= BUS_WDATA[`IRRX_CTL_IIE];
				rxen_q   <= BUS_WDATA[`IRRX_CTL_RXEN];
				paddle_q <= BUS_WDATA[`IRRX_CTL_PADDLE];
			end
			if (wr_cc)
				exp_cc_q <= BUS_WDATA[15:0];
			// [RQ6] leader width field
			if (wr_tcount)
				leader_q <= BUS_WDATA[13:8];
			// [RQ7] bit width field
			if (wr_tcount)
				bitw_q <= BUS_WDATA[5:0];
			if (wr_ien)
				ien_q <= BUS_WDATA[7:0];
		end
	end

	// ==============================================================
	// captured codes from the decoder
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			// [RQ13] captures cleared
			rcv_cc_q <= 16'h0000;
			key_q    <= 16'h0000;
		end
		else if (frame_ev)
		begin
			// [RQ2] received code capture
			rcv_cc_q <= DEC_IN.cust_code & cmask;
			// [RQ3] key layout per mode
			key_q    <= {DEC_IN.key_anti, DEC_IN.key_data} & kmask;
		end
		// [RQ4] repeats leave key alone
	end

	// ==============================================================
	// sticky status flags; a set in the clearing cycle wins
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			cust_mis_q  <= 1'b0;
			key_mis_q   <= 1'b0;
			repeat_q    <= 1'b0;
			rxirq_q     <= 1'b0;
			proterr_q   <= 1'b0;
			last_good_q <= 1'b0;
		end
		else
		begin
			// [RQ11] mismatch flag set/clear
			if (frame_ev && !cust_ok)
				cust_mis_q <= 1'b1;
			else if (good_ev || clr_bits[`IRRX_ST_CUSTMIS])
				cust_mis_q <= 1'b0;

			// key mismatch behaves the same way for the anti-key check
			if (frame_ev && !key_ok)
				key_mis_q <= 1'b1;
			else if (good_ev || clr_bits[`IRRX_ST_KEYMIS])
				key_mis_q <= 1'b0;

			if (repeat_ev)
				repeat_q <= 1'b1;
			else if (clr_bits[`IRRX_ST_REPEAT])
				repeat_q <= 1'b0;

			// [RQ12] correct frames, or repeats following a correct frame
			if (irq_set)
				rxirq_q <= 1'b1;
			else if (clr_bits[`IRRX_ST_RXIRQ])
				rxirq_q <= 1'b0;

			if (err_ev)
				proterr_q <= 1'b1;
			else if (good_ev || clr_bits[`IRRX_ST_PROTERR])
				proterr_q <= 1'b0;

			// remembers whether repeats may interrupt
			if (frame_ev)
				last_good_q <= cust_ok && key_ok;
			else if (err_ev)
				last_good_q <= 1'b0;
		end
	end

	// ==============================================================
	// paddle buffer pointers; a word arriving when full is dropped
	// and flagged, since the decoder cannot be held off mid-frame
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			// [RQ13] buffer emptied
			wr_ptr_q <= 3'h0;
			rd_ptr_q <= 3'h0;
			count_q  <= 4'h0;
			ovf_q    <= 1'b0;
		end
		else
		begin
			// [RQ5] push and pop
			if (push)
				wr_ptr_q <= wr_ptr_q + 3'h1;
			if (pop)
				rd_ptr_q <= rd_ptr_q + 3'h1;
			if (push && !pop)
				count_q <= count_q + 4'h1;
			else if (pop && !push)
				count_q <= count_q - 4'h1;
			if (pad_on && DEC_IN.pad_valid && fifo_full)
				ovf_q <= 1'b1;
			else if (wr_ctl)
				ovf_q <= 1'b0;
		end
	end

	// paddle word storage, written only at the tail
	always_ff @(posedge MCLK)
	begin
		if (push)
			fifo_mem_q[wr_ptr_q] <= DEC_IN.pad_word;
	end
	assign PAD_OVERFLOW = ovf_q;

	// ==============================================================
	// 10 us unit tick: two cycles of the 200 kHz source
	localparam logic [11:0] UNIT_LAST = 12'(`IRRX_UNIT_CYCLES - 1);
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			unit_cnt_q  <= 12'h000;
			unit_tick_q <= 1'b0;
		end
		else if (unit_cnt_q == UNIT_LAST)
		begin
			unit_cnt_q  <= 12'h000;
			unit_tick_q <= 1'b1;
		end
		else
		begin
			unit_cnt_q  <= unit_cnt_q + 12'h001;
			unit_tick_q <= 1'b0;
		end
	end

	// ==============================================================
	// settings seen by the line decoder
	// one assignment, so the whole struct has a single driver
	assign DEC_CFG = '{mode:         mode_q,
	                   rx_enable:    rxen_q,
	                   paddle:       paddle_q,
	                   leader_units: leader_q,
	                   bit_units:    bitw_q,
	                   unit_tick:    unit_tick_q};

endmodule

`default_nettype wire

// ---- rtl/irrx_regs.svh ----
// register offsets, field positions, reset values and timing counts
// of the infrared code receiver register block; definitions only
`ifndef IRRX_REGS_SVH
`define IRRX_REGS_SVH

// ==================================================================
// register byte offsets
`define IRRX_OFS_CTL      8'h00
`define IRRX_OFS_STAT     8'h04
`define IRRX_OFS_CC       8'h08
`define IRRX_OFS_KDC      8'h0c
`define IRRX_OFS_TCOUNT   8'h10
`define IRRX_OFS_RCC      8'h14
`define IRRX_OFS_ICLR     8'h18
`define IRRX_OFS_IEN      8'h1c

// ==================================================================
// control register fields
`define IRRX_CTL_PADDLE   4
`define IRRX_CTL_RXEN     3
`define IRRX_CTL_IIE      2

// ==================================================================
// status register fields
`define IRRX_ST_NEMPTY    7
`define IRRX_ST_CUSTMIS   6
`define IRRX_ST_KEYMIS    5
`define IRRX_ST_REPEAT    4
`define IRRX_ST_RXIRQ     2
`define IRRX_ST_PROTERR   0
`define IRRX_ST_W1C_MASK  8'h75

// ==================================================================
// reset values
`define IRRX_LEADER_RST   6'h0f
`define IRRX_BITW_RST     6'h15

// ==================================================================
// timing: 200 kHz source tick, the 10 us unit tick is two source cycles
`define IRRX_CLK_PERIOD_NS   4
`define IRRX_SRC_PERIOD_NS   5000
`define IRRX_UNIT_SRC_CYC    2
`define IRRX_UNIT_CYCLES     ((`IRRX_SRC_PERIOD_NS * `IRRX_UNIT_SRC_CYC) / `IRRX_CLK_PERIOD_NS)

// ==================================================================
// paddle receive buffer
`define IRRX_FIFO_DEPTH   8
`define IRRX_PAD_WIDTH    20

`endif

// ---- tb/irrx_dec_model.sv ----
// stand-in for the line decoder facing a remote or paddle
// assumes the bench calls send between its own bus accesses
`timescale 1ns/1ns
`default_nettype none
module irrx_dec_model
	import irrx_pkg::*;
(
	input  wire logic          clk,
	output irrx_pkg::irrx_dec_t dec
);
	initial dec = '0;
	// ==========================================================
	// one pulse, then the data lines are driven inverted so nothing may rely on them
	task automatic send(input logic [3:0] kind, input logic [15:0] cc, input logic [7:0] k,
		input logic [7:0] a, input logic [19:0] w);
		@(posedge clk);
		dec <= '{kind[0], kind[1], kind[2], cc, k, a, kind[3], w};
		@(posedge clk);
		dec <= '{1'b0, 1'b0, 1'b0, ~cc, ~k, ~a, 1'b0, ~w};
	endtask
endmodule
`default_nettype wire

// ---- tb/irrx_properties.sv ----
// assertions on the port behaviour of the receiver register block
// assumes it is bound to irrx_regblock and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module irrx_properties
(
	input wire logic                MCLK,
	input wire logic                SYS_RST,
	input wire logic [7:0]          BUS_ADDR,
	input wire logic [31:0]         BUS_WDATA,
	input wire logic                BUS_WR,
	input wire logic                BUS_RD,
	input wire logic [31:0]         BUS_RDATA,
	input wire irrx_pkg::irrx_dec_t DEC_IN,
	input wire irrx_pkg::irrx_cfg_t DEC_CFG,
	input wire logic                PAD_OVERFLOW,
	input wire logic                IRQ
);
	logic [11:0] gap_q;
	logic        seen_q;
	// ==========================================================
	// tick spacing; the first tick after reset is only bounded
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			gap_q  <= 12'h0;
			seen_q <= 1'b0;
		end
		else
		begin
			gap_q  <= DEC_CFG.unit_tick ? 12'h0 : gap_q + 12'h1;
			seen_q <= seen_q | DEC_CFG.unit_tick;
		end
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (SYS_RST);
	// ==========================================================
	// assertions
	rdata_idle_a: assert property (!$past(BUS_RD) |-> BUS_RDATA == 32'h0)
		else $error("stray read data");
	reset_dflt_a: assert property (disable iff (1'b0) SYS_RST |=>
		DEC_CFG.leader_units == 6'h0f && DEC_CFG.bit_units == 6'h15 && !IRQ && !PAD_OVERFLOW)
		else $error("bad reset state");
	tcount_wr_a: assert property (BUS_WR && BUS_ADDR == 8'h10 |=>
		{DEC_CFG.leader_units, DEC_CFG.bit_units} == {$past(BUS_WDATA[13:8]), $past(BUS_WDATA[5:0])})
		else $error("timing not written");
	mode_wr_a: assert property (BUS_WR && BUS_ADDR == 8'h00 |=>
		{DEC_CFG.paddle, DEC_CFG.rx_enable, DEC_CFG.mode} == {$past(BUS_WDATA[4:3]), $past(BUS_WDATA[1:0])})
		else $error("control not written");
	irq_cause_a: assert property ($rose(IRQ) |-> $past(BUS_WR || DEC_IN.frame_done ||
		DEC_IN.repeat_seen || DEC_IN.proto_err || DEC_IN.pad_valid)) else $error("irq without cause");
	ovf_cause_a: assert property ($rose(PAD_OVERFLOW) |->
		$past(DEC_IN.pad_valid && DEC_CFG.paddle)) else $error("overflow without word");
	quiet_off_a: assert property (!DEC_CFG.rx_enable && !BUS_WR && !BUS_RD |=> $stable(IRQ))
		else $error("irq moved while off");
	tick_period_a: assert property (DEC_CFG.unit_tick && seen_q |-> gap_q == 12'd2499)
		else $error("tick period");
	tick_bound_a: assert property (gap_q < 12'd2502)
		else $error("tick missing");
	cover property (DEC_IN.frame_done ##1 IRQ);
	cover property ($rose(PAD_OVERFLOW));
	cover property (DEC_CFG.unit_tick && seen_q);
endmodule
bind irrx_regblock irrx_properties irrx_properties_inst (.MCLK(MCLK), .SYS_RST(SYS_RST),
	.BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_WR(BUS_WR), .BUS_RD(BUS_RD),
	.BUS_RDATA(BUS_RDATA), .DEC_IN(DEC_IN), .DEC_CFG(DEC_CFG), .PAD_OVERFLOW(PAD_OVERFLOW),
	.IRQ(IRQ));
`default_nettype wire

// ---- tb/tb.sv ----
// bench for the receiver register block: bus tasks and scripted checks
// assumes the checker binds itself to the block
`timescale 1ns/1ns
`default_nettype none
module tb;
	import irrx_pkg::*;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	irrx_dec_t   dec;
	irrx_cfg_t   cfg;
	logic        ovf;
	logic        irq;
	int          fails = 0;
	int          num_checks = 0;
	logic [15:0] cmask [4] = '{16'hffff, 16'hffff, 16'h001f, 16'h00ff};
	logic [15:0] kexp [4] = '{16'h15ea, 16'h15ea, 16'h002a, 16'h00ea};
	// ==========================================================
	// clock and parts
	initial
	begin
		forever #2 mclk = ~mclk;
	end
	irrx_regblock irrx_regblock_inst (.MCLK(mclk), .SYS_RST(rst), .BUS_ADDR(addr),
		.BUS_WDATA(wdata), .BUS_WR(wr), .BUS_RD(rd), .BUS_RDATA(rdata), .DEC_IN(dec),
		.DEC_CFG(cfg), .PAD_OVERFLOW(ovf), .IRQ(irq));
	irrx_dec_model dm (.clk(mclk), .dec(dec));
	// ==========================================================
	// tasks
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
		#1;
	endtask
	// the answer stands one cycle only, so it is taken mid-cycle
	task automatic rreg(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		check(rdata, e);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	initial
	begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		rreg(8'h10, 32'h0f15);
		rreg(8'h14, 32'h0);
		rreg(8'h20, 32'h0);
		wreg(8'h10, 32'hffff_ffff);
		rreg(8'h10, 32'h3f3f);
		wreg(8'h08, 32'hffff_abcd);
		rreg(8'h08, 32'habcd);
		wreg(8'h1c, 32'h75);
		for (int m = 0; m < 4; m++)
		begin
			wreg(8'h00, 32'h0c | 32'(m));
			dm.send(4'h1, 16'habcd, 8'hea, 8'h15, 20'h0);
			rreg(8'h14, {16'h0, 16'habcd & cmask[m]});
			rreg(8'h0c, {16'h0, kexp[m]});
			check(irq, 32'h1);
			wreg(8'h18, 32'h75);
			check(irq, 32'h0);
		end
		// repeat, bad code, masking and error flags in nec mode
		wreg(8'h00, 32'h0d);
		dm.send(4'h2, 16'habcd, 8'h77, 8'h88, 20'h0);
		rreg(8'h0c, 32'h00ea);
		rreg(8'h04, 32'h14);
		wreg(8'h18, 32'h75);
		// only the receive bit may drive the line while codes are bad
		wreg(8'h1c, 32'h04);
		dm.send(4'h1, 16'h0bad, 8'h33, 8'hcc, 20'h0);
		dm.send(4'h2, 16'h0bad, 8'h33, 8'hcc, 20'h0);
		rreg(8'h04, 32'h50);
		check(irq, 32'h0);
		dm.send(4'h1, 16'habcd, 8'hea, 8'h15, 20'h0);
		rreg(8'h04, 32'h14);
		wreg(8'h1c, 32'h0);
		check(irq, 32'h0);
		wreg(8'h1c, 32'h75);
		check(irq, 32'h1);
		dm.send(4'h4, 16'h0, 8'h0, 8'h0, 20'h0);
		rreg(8'h04, 32'h15);
		wreg(8'h04, 32'h15);
		rreg(8'h04, 32'h0);
		dm.send(4'h1, 16'habcd, 8'h33, 8'h00, 20'h0);
		rreg(8'h04, 32'h20);
		wreg(8'h18, 32'h75);
		// paddle mode needs the receiver enabled as well
		wreg(8'h00, 32'h1c);
		dm.send(4'h1, 16'h5555, 8'h01, 8'hfe, 20'h0);
		rreg(8'h04, 32'h0);
		for (int i = 0; i < 9; i++)
			dm.send(4'h8, 16'h0, 8'h0, 8'h0, 20'h8_0000 + 20'(i));
		rreg(8'h04, 32'h84);
		check(ovf, 32'h1);
		for (int i = 0; i < 8; i++)
			rreg(8'h0c, 32'h8_0000 + 32'(i));
		rreg(8'h04, 32'h0);
		// reset in mid-run with a word queued
		dm.send(4'h8, 16'h0, 8'h0, 8'h0, 20'h1);
		wreg(8'h10, 32'h0);
		@(posedge mclk);
		rst <= 1'b1;
		@(posedge mclk);
		rst <= 1'b0;
		rreg(8'h10, 32'h0f15);
		rreg(8'h04, 32'h0);
		rreg(8'h14, 32'h0);
		check(ovf, 32'h0);
		repeat (5200) @(posedge mclk);
		report_and_stop;
	end
endmodule
`default_nettype wire
